// file: hw/cpw_core.sv
// Complementary PWM core: host latches, period counter, enable, duty decode
//
// Summary of operation
// - Reset selects 8-bit resolution
// - Base period 256 or 128 PWM clocks
// - Halving bit doubles PWM clock period
// - Pulse width sets primary high time
// - Dead-time shortens each on-time, period unchanged
// - Stop zero forces both outputs low
// - Stop writable even when locked
// - Inhibit pin low forces both outputs low
// - Resume only at start of enabled period
// - Resolution bit: zero 7-bit, one 8-bit
// - Duty equals value over 128 or 256
// - One means 0%, all ones 100%
// - Width writes always stored, used on re-enable
// - Dead-time two clocks per count, undivided
// - Control layout: dt, rsvd, lock, div, res, stop
// - Lock freezes all bits but stop
// - Reset loads 01000111 and clears width
`timescale 1ns/1ns
`default_nettype none
`include "cpw_consts.svh"

module cpw_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] bus_data,
  input wire logic bus_sel,
  input wire logic bus_cs_n,
  input wire logic bus_wr_n,
  input wire logic hardware_output_inhibit_pin_n,
  output logic primary_output,
  output logic complementary_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Duty decode used only by the datapath to form raw_high
  function automatic logic cpw_duty_high(
    input logic [7:0] pw,
    input logic [7:0] cnt,
    input logic res8
  );
    logic hi;
    hi = 1'b0;
    if (res8)
    begin
      // 8-bit: all ones is full on, 0 and 1 are off
      if (pw == `CPW_CNT_MAX8)
        hi = 1'b1;
      else if (pw[7:1] == 7'h00)
        hi = 1'b0;
      else
        hi = cnt < pw;
    end
    else
    begin
      // 7-bit: top bit set or low seven all ones is full on
      if (pw[7] || pw[6:0] == `CPW_CNT_MAX7)
        hi = 1'b1;
      else if (pw[6:0] <= `CPW_PW_ZERO_MAX)
        hi = 1'b0;
      else
        hi = cnt[6:0] < pw[6:0];
    end
    return hi;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and combinational helpers
  cpw_pkg::cpw_core_t s_reg;   // Registered state
  cpw_pkg::cpw_core_t s_next;  // Next state
  cpw_pkg::cpw_pins_t pins;    // Raw pin sample
  cpw_pkg::cpw_ctrl_t wr_ctrl; // Byte seen as a control word
  logic wr_evt;                // Completed write strobe
  logic period_start;          // Last PWM clock of the period
  logic [7:0] cnt_max;         // Last count for the current resolution
  logic run_ok;                // Neither stop nor inhibit active
  logic raw_high;              // Undelayed primary level

  assign pins = '{data: bus_data, sel: bus_sel, cs_n: bus_cs_n,
                  wr_n: bus_wr_n, inh_n: hardware_output_inhibit_pin_n};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_next = s_reg;
    // Two-stage synchroniser; only the second stage is looked at
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.wr_n_d = s_reg.s2.wr_n;

    // Write completes on the rising strobe while selected
    wr_evt = !s_reg.s2.cs_n && !s_reg.wr_n_d && s_reg.s2.wr_n;
    wr_ctrl = cpw_pkg::cpw_ctrl_t'(s_reg.s2.data);

    // Width register takes every write with sel low, even while disabled
    if (wr_evt && !s_reg.s2.sel)
    begin
      s_next.pw = s_reg.s2.data;
    end

    // Control register; lock leaves only stop writable
    if (wr_evt && s_reg.s2.sel)
    begin
      s_next.ctrl.stop = wr_ctrl.stop;
      if (!s_reg.ctrl.lock)
      begin
        // Lock cannot be cleared by a write, only by reset
        s_next.ctrl.lock = wr_ctrl.lock;
        s_next.ctrl.res8 = wr_ctrl.res8;
        s_next.ctrl.div2 = wr_ctrl.div2;
        s_next.ctrl.dt = wr_ctrl.dt;
        s_next.ctrl.rsvd = 1'b0;
      end
    end

    // Divider: every clock, or every other clock when halved
    s_next.tick = s_reg.ctrl.div2 ? !s_reg.tick : 1'b1;

    // Period end; >= also recovers if resolution drops mid-period
    cnt_max = s_reg.ctrl.res8 ? `CPW_CNT_MAX8 : `CPW_CNT_MAX7;
    period_start = s_reg.tick && (s_reg.cnt >= cnt_max);
    if (s_reg.tick)
    begin
      s_next.cnt = period_start ? `CPW_CNT_FIRST : s_reg.cnt + 8'h01;
    end

    // Disable at once; re-enable only on a period boundary
    run_ok = s_reg.ctrl.stop && s_reg.s2.inh_n;
    if (!run_ok)
    begin
      s_next.en = 1'b0;
    end
    else if (period_start)
    begin
      s_next.en = 1'b1;
    end

    // Decode against next count so outputs line up with the counter
    raw_high = cpw_duty_high(s_next.pw, s_next.cnt, s_next.ctrl.res8);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves outputs stopped and unlocked
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.ctrl <= `CPW_CTRL_RST;
      s_reg.pw <= `CPW_PW_RST;
      s_reg.tick <= 1'b1;
      // Synchroniser starts at idle bus levels, so no false strobe edge
      s_reg.s1.cs_n <= 1'b1;
      s_reg.s1.wr_n <= 1'b1;
      s_reg.s2.cs_n <= 1'b1;
      s_reg.s2.wr_n <= 1'b1;
      s_reg.wr_n_d <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead-time stage; both outputs come from its flip-flops
  cpw_deadtime u_dead (
    .clk(clk),
    .nrst(nrst),
    .raw_high(raw_high),
    .enable(s_next.en),
    .dt(s_reg.ctrl.dt),
    .primary_output(primary_output),
    .complementary_output(complementary_output)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  reset_value_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> (s_reg.ctrl == `CPW_CTRL_RST && s_reg.pw == 8'h00))
    else $error("control or width wrong after reset");

  stop_low_a: assert property (@(posedge clk) disable iff (!nrst)
    !s_reg.ctrl.stop |=> (!primary_output && !complementary_output))
    else $error("outputs active while stopped");

  inhibit_low_a: assert property (@(posedge clk) disable iff (!nrst)
    !s_reg.s2.inh_n |=> (!primary_output && !complementary_output))
    else $error("outputs active while inhibited");

  resume_at_start_a: assert property (@(posedge clk)
    disable iff (!nrst)
    $rose(s_reg.en) |-> (s_reg.cnt == 8'h00 && $past(period_start)))
    else $error("outputs resumed mid-period");

  lock_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_reg.ctrl.lock && wr_evt && s_reg.s2.sel)
    |=> (s_reg.ctrl[6:0] == $past(s_reg.ctrl[6:0])
         && s_reg.ctrl.stop == $past(s_reg.s2.data[7])))
    else $error("locked control bits changed or stop lost");

  width_store_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_evt && !s_reg.s2.sel) |=> s_reg.pw == $past(s_reg.s2.data))
    else $error("width write not stored");

  period8_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_reg.tick && s_reg.ctrl.res8 && s_reg.cnt == 8'hFF)
    |=> s_reg.cnt == 8'h00)
    else $error("8-bit period did not wrap at 255");

  period7_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_reg.tick && !s_reg.ctrl.res8 && s_reg.cnt == 8'h7F)
    |=> s_reg.cnt == 8'h00)
    else $error("7-bit period did not wrap at 127");

  half_clock_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_reg.ctrl.div2 && $past(s_reg.ctrl.div2) && s_reg.tick)
    |=> (!s_reg.tick ##1 $stable(s_reg.cnt)))
    else $error("halved PWM clock advanced twice in a row");

  end_points_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_next.pw == 8'h01) |-> !raw_high)
    else $error("width of one not decoded as zero duty");

  full_seven_a: assert property (@(posedge clk) disable iff (!nrst)
    (!s_next.ctrl.res8 && s_next.pw[7]) |-> raw_high)
    else $error("7-bit top bit not decoded as full duty");

  inverse_a: assert property (@(posedge clk) disable iff (!nrst)
    (primary_output || complementary_output)
    |-> (primary_output != complementary_output))
    else $error("outputs not complementary");

endmodule
`default_nettype wire

// file: hw/cpw_deadtime.sv
// Dead-time insertion stage driving both PWM outputs from flip-flops
`timescale 1ns/1ns
`default_nettype none
`include "cpw_consts.svh"

module cpw_deadtime (
  input wire logic clk,
  input wire logic nrst,
  input wire logic raw_high,
  input wire logic enable,
  input wire logic [2:0] dt,
  output logic primary_output,
  output logic complementary_output
);

  // Current and next state
  cpw_pkg::cpw_dead_t s_reg;
  cpw_pkg::cpw_dead_t s_next;
  // An output that is high is about to drop
  logic turn_off;
  // Dead-time load value for this cycle
  logic [3:0] dead_load;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: a turn-off starts the dead-time, which overlaps the on-time
  always_comb
  begin
    s_next = s_reg;
    turn_off = (s_reg.pri && !raw_high) || (s_reg.comp && raw_high);
    dead_load = 4'h0;
    if (turn_off)
    begin
      // Two clocks per count, independent of the PWM divider
      dead_load = 4'({1'b0, dt} * `CPW_DT_CLKS_PER_COUNT);
    end
    else if (s_reg.dcnt != 4'h0)
    begin
      dead_load = s_reg.dcnt - 4'h1;
    end
    if (!enable)
    begin
      // Disabled: both low, no pending dead-time on re-enable
      s_next.pri = 1'b0;
      s_next.comp = 1'b0;
      s_next.dcnt = 4'h0;
    end
    else
    begin
      // Outside dead-time the two outputs are exact inverses
      s_next.dcnt = dead_load;
      s_next.pri = raw_high && (dead_load == 4'h0);
      s_next.comp = !raw_high && (dead_load == 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign primary_output = s_reg.pri;
  assign complementary_output = s_reg.comp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  no_overlap_a: assert property (@(posedge clk) disable iff (!nrst)
    !(s_reg.pri && s_reg.comp))
    else $error("both outputs high together");

  // Once no dead-time is pending, the pair must be exact inverses
  inv_steady_a: assert property (@(posedge clk) disable iff (!nrst)
    ($past(enable) && s_reg.dcnt == 4'h0) |-> (s_reg.pri != s_reg.comp))
    else $error("outputs not inverse outside dead-time");

  dead_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(s_reg.pri) && enable && dt == 3'h3 && $stable(dt))
    |-> !s_reg.comp [*6])
    else $error("dead-time shorter than six clocks");

endmodule
`default_nettype wire

// file: inc/cpw_consts.svh
// Constants for the complementary PWM core: reset values, limits, timing
`ifndef CPW_CONSTS_SVH
`define CPW_CONSTS_SVH

// Control register after reset: stopped, 8-bit, undivided, unlocked, dt 7
`define CPW_CTRL_RST 8'h47
// Pulse width register after reset
`define CPW_PW_RST 8'h00
// Last count of a base period in 8-bit and 7-bit resolution
`define CPW_CNT_MAX8 8'hFF
`define CPW_CNT_MAX7 8'h7F
// First count of a base period
`define CPW_CNT_FIRST 8'h00
// Largest pulse width value that still means zero duty
`define CPW_PW_ZERO_MAX 7'h01
// External clock periods per dead-time count
`define CPW_DT_CLKS_PER_COUNT 4'h2

`endif

// file: inc/cpw_pkg.sv
// Types shared by the complementary PWM core and its dead-time stage
package cpw_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic stop;      // Zero holds both outputs low
    logic res8;      // One selects 8-bit, zero 7-bit resolution
    logic div2;      // One halves the PWM clock
    logic lock;      // One freezes every bit but stop
    logic rsvd;      // Reserved, reads as zero
    logic [2:0] dt;  // Dead-time count
  } cpw_ctrl_t;

  // Sampled host bus and inhibit pin
  typedef struct packed {
    logic [7:0] data;
    logic sel;
    logic cs_n;
    logic wr_n;
    logic inh_n;
  } cpw_pins_t;

  // Whole state of the core
  typedef struct packed {
    cpw_pins_t s1;      // First synchroniser stage
    cpw_pins_t s2;      // Second synchroniser stage
    logic wr_n_d;       // Delayed write strobe for edge detection
    cpw_ctrl_t ctrl;    // Control register
    logic [7:0] pw;     // Pulse width register
    logic tick;         // PWM clock enable from the divider
    logic [7:0] cnt;    // Pulse width counter
    logic en;           // Outputs allowed to switch
  } cpw_core_t;

  // Whole state of the dead-time stage
  typedef struct packed {
    logic pri;          // Primary output
    logic comp;         // Complementary output
    logic [3:0] dcnt;   // Remaining dead-time clocks
  } cpw_dead_t;

endpackage

// file: testbench/complementary_pwm_core_tb.sv
// Self-checking bench for the complementary PWM core
`timescale 1ns/1ns
`default_nettype none

module complementary_pwm_core_tb;
  logic clk; // 20 MHz clock
  logic nrst; // Reset, active low
  logic inh_n; // Inhibit pin, active low
  logic req, req_sel, req_skip, ack;
  logic [7:0] req_data, bus_data;
  logic bus_sel, bus_cs_n, bus_wr_n, pri, comp;
  int error_cnt, tests_run;
  logic [31:0] seed; // Xorshift state
  int m_pw, m_r8, m_d2, m_dt, m_stop, m_lock; // Reference register copy
  logic [8:0] edges [6]; // Resolution bit and width for end points
  int i, n, p;
  logic [31:0] r;

  ////////////////////////////////////////////////////////////////////////////
  // Design and host
  cpw_core u_cpw_core (.clk(clk), .nrst(nrst), .bus_data(bus_data),
    .bus_sel(bus_sel), .bus_cs_n(bus_cs_n), .bus_wr_n(bus_wr_n),
    .hardware_output_inhibit_pin_n(inh_n), .primary_output(pri),
    .complementary_output(comp));
  cpw_host_model u_cpw_host_model (.clk(clk), .req(req), .req_sel(req_sel),
    .req_skip(req_skip), .req_data(req_data), .ack(ack),
    .bus_data(bus_data), .bus_sel(bus_sel), .bus_cs_n(bus_cs_n),
    .bus_wr_n(bus_wr_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One host write, mirrored into the reference copy
  task automatic wr(input logic s, input logic [7:0] d, input logic skip);
    int k;
    @(posedge clk);
    req_sel <= s;
    req_data <= d;
    req_skip <= skip;
    req <= 1'b1;
    for (k = 0; k < 40 && ack !== 1'b1; k++)
      @(posedge clk);
    req <= 1'b0;
    chk("bus_ack", 16'(k < 40), 16'd1);
    if (!skip && !s)
      m_pw = d;
    // Lock leaves only stop writable; only reset clears it
    if (!skip && s)
    begin
      m_stop = d[7];
      if (!m_lock)
      begin
        m_r8 = d[6];
        m_d2 = d[5];
        m_lock = d[4];
        m_dt = d[2:0];
      end
    end
  endtask

  // Expected high clocks in one base period
  function automatic int exp_hi(input int c);
    int pp, mm, nn, on;
    pp = m_r8 ? 256 : 128;
    mm = m_d2 ? 2 : 1;
    nn = m_r8 ? m_pw : (m_pw[7] ? 128 : m_pw[6:0]);
    if (nn == pp - 1)
      nn = pp;
    if (nn <= 1)
      nn = 0;
    if (!m_stop || inh_n !== 1'b1)
      return 0;
    on = c ? (pp - nn) * mm : nn * mm;
    // End points carry no dead time; otherwise 2 clocks a count
    if (on == 0 || on == pp * mm)
      return on;
    on = on - 2 * m_dt;
    return on < 0 ? 0 : on;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Settle, then count high clocks over exactly one base period
  task automatic meas();
    int h1, h2, hb, k;
    h1 = 0;
    h2 = 0;
    hb = 0;
    repeat (1100) @(posedge clk);
    for (k = 0; k < (m_r8 ? 256 : 128) * (m_d2 ? 2 : 1); k++)
    begin
      @(posedge clk);
      h1 += (pri === 1'b1);
      h2 += (comp === 1'b1);
      hb += (pri !== 1'b0 && comp !== 1'b0);
    end
    chk("primary", 16'(h1), 16'(exp_hi(0)));
    chk("compl", 16'(h2), 16'(exp_hi(1)));
    chk("overlap", 16'(hb), 16'd0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the expected run length
  initial
  begin
    #4000000;
    error_cnt++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    inh_n = 1'b1;
    req = 1'b0;
    req_sel = 1'b0;
    req_skip = 1'b0;
    req_data = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    seed = 32'hc707;
    {m_pw, m_r8, m_d2, m_dt, m_stop, m_lock} = {32'h0, 32'h1, 32'h0,
      32'h7, 32'h0, 32'h0};
    edges = '{9'h1_00, 9'h1_01, 9'h1_FF, 9'h0_7F, 9'h0_90, 9'h1_02};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    meas(); // Stopped after reset
    wr(1'b1, 8'hC7, 1'b0);
    meas(); // Width cleared by reset
    // Random widths, modes and dead times
    for (i = 0; i < 10; i++)
    begin
      r = xs();
      p = r[0] ? 256 : 128;
      n = 16 + int'(xs() % 32'(p - 32));
      wr(1'b0, 8'(n), 1'b0);
      wr(1'b1, {1'b1, r[0], r[1], 2'b00, r[4:2]}, 1'b0);
      meas();
    end
    // End points of the duty table
    for (i = 0; i < 6; i++)
    begin
      wr(1'b1, {1'b1, edges[i][8], 6'h00}, 1'b0);
      wr(1'b0, edges[i][7:0], 1'b0);
      meas();
    end
    wr(1'b0, 8'h33, 1'b1);
    meas(); // Chip select high writes nothing
    wr(1'b1, 8'h43, 1'b0);
    wr(1'b0, 8'h60, 1'b0);
    meas(); // Stop low, new width held back
    wr(1'b1, 8'hC3, 1'b0);
    meas(); // Resume with latest width
    inh_n <= 1'b0;
    wr(1'b0, 8'hA0, 1'b0);
    meas(); // Pin inhibits like stop
    inh_n <= 1'b1;
    meas(); // Pin released
    wr(1'b1, 8'hD2, 1'b0);
    wr(1'b1, 8'hA5, 1'b0);
    meas(); // Locked settings unchanged
    wr(1'b1, 8'h05, 1'b0);
    meas(); // Stop works while locked
    wr(1'b1, 8'h85, 1'b0);
    meas();
    test_done();
  end
endmodule
`default_nettype wire

// file: testbench/cpw_host_model.sv
// Host bus writer model: turns one byte request into a pin-level write
`timescale 1ns/1ns
`default_nettype none

module cpw_host_model (
  input wire logic clk,
  input wire logic req,
  input wire logic req_sel,
  input wire logic req_skip,
  input wire logic [7:0] req_data,
  output logic ack,
  output logic [7:0] bus_data,
  output logic bus_sel,
  output logic bus_cs_n,
  output logic bus_wr_n
);
  int step; // Position within one bus cycle, zero when idle

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial
  begin
    ack = 1'b0;
    bus_data = 8'h00;
    bus_sel = 1'b0;
    bus_cs_n = 1'b1;
    bus_wr_n = 1'b1;
    step = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe held four clocks so the two-flop synchroniser surely sees it
  always @(posedge clk)
  begin
    ack <= 1'b0;
    if (step == 0)
    begin
      // A write may come at any time, enabled or not
      if (req && !ack)
      begin
        bus_data <= req_data;
        bus_sel <= req_sel;
        bus_cs_n <= req_skip; // Skip keeps chip select high
        bus_wr_n <= 1'b0;
        step <= 1;
      end
    end
    else
    begin
      step <= step + 1;
      // Rising strobe ends the write
      if (step == 4)
        bus_wr_n <= 1'b1;
      // Released lines show no stale value
      if (step == 6)
      begin
        bus_cs_n <= 1'b1;
        bus_data <= ~bus_data;
        bus_sel <= ~bus_sel;
      end
      // Gap after the strobe keeps writes apart
      if (step == 10)
      begin
        ack <= 1'b1;
        step <= 0;
      end
    end
  end
endmodule
`default_nettype wire
